// *** test/ccs_clock_ctrl_asserts.sv ***
// Port-level checker of the clock source control, bound to its top module
`timescale 1ns/1ps
`include "ccs_cfg.svh"
module ccs_clock_ctrl_chk (
  // Clock, reset and register access
  input wire logic        i_mclk,
  input wire logic        i_rst,
  input wire logic        i_sfr_wr,
  input wire logic [7:0]  i_sfr_addr,
  input wire logic        i_xsfr_wr,
  input wire logic [15:0] i_xsfr_addr,
  input wire logic [7:0]  i_wdata,
  input wire logic [7:0]  o_trim_rdata,
  input wire logic [7:0]  o_clock_switch_control_rdata,
  // Control and status
  input wire logic        i_low_power_clock_bit_wr,
  input wire logic        i_low_power_clock_bit_wdata,
  input wire logic        i_rtc_uses_crystal,
  input wire logic [2:0]  o_active_source,
  input wire logic        o_cpu_clock_en,
  input wire logic        o_periph_clock_en,
  input wire logic        o_crystal_for_watchdog,
  input wire logic        o_low_power_clock_bit,
  input wire logic        o_clock_output_pin_oe
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  wire con_wr = i_xsfr_wr && i_xsfr_addr == `CCS_CLOCK_SWITCH_CONTROL_ADDR;
  wire done = o_clock_switch_control_rdata[7];
  a_oe_needs_enable: assert property (o_clock_output_pin_oe |-> o_trim_rdata[6])
    else $error("clock output driven while disabled");
  a_oe_crystal_free: assert property (o_clock_output_pin_oe |->
    !(o_crystal_for_watchdog || i_rtc_uses_crystal || o_active_source < 3'h3))
    else $error("clock output driven while crystal in use");
  a_done_falls: assert property (con_wr && done |=> !done)
    else $error("done flag kept high after switch start");
  a_busy_write_dropped: assert property (con_wr && !done |=> $stable(o_clock_switch_control_rdata[4:0]))
    else $error("clock control changed during switch");
  a_trim_write: assert property (i_sfr_wr && i_sfr_addr == `CCS_TRIM_ADDR |=> o_trim_rdata == $past(i_wdata))
    else $error("trim write not taken");
  a_rc_override: assert property (o_trim_rdata[7] && $past(o_trim_rdata[7]) |-> o_active_source == `CCS_SRC_RC)
    else $error("rc override not active");
  a_low_power_write: assert property (i_low_power_clock_bit_wr |=>
    o_low_power_clock_bit == $past(i_low_power_clock_bit_wdata)) else $error("low power bit not written");
  a_periph_half: assert property (o_periph_clock_en |-> o_cpu_clock_en)
    else $error("peripheral pulse without cpu pulse");
  a_xtal_watchdog: assert property (con_wr && done |=> o_crystal_for_watchdog == $past(i_wdata[4]))
    else $error("watchdog crystal select mismatch");
  a_reserved_zero: assert property (o_clock_switch_control_rdata[6:5] == 2'h0)
    else $error("reserved clock control bits set");
endmodule : ccs_clock_ctrl_chk

bind ccs_clock_ctrl ccs_clock_ctrl_chk i_chk (.*);

// *** test/ccs_clock_ctrl_tb.sv ***
// Self-checking bench for the clock source control
`timescale 1ns/1ps
`include "ccs_cfg.svh"
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin miscompares++; $display("mismatch %s exp %h got %h", n, e, s); end end
module ccs_clock_ctrl_tb;
  localparam logic [5:0] TF = 6'h2A;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic        sfr_wr = 1'b0;
  logic [7:0]  sfr_addr = 8'h00;
  logic        xwr = 1'b0;
  logic [15:0] xaddr = 16'h0000;
  logic [7:0]  wdata = 8'h00;
  logic [7:0]  user_config_byte_one = 8'h04;
  logic [7:0]  user_config_byte_two = 8'h00;
  logic [7:0]  div = 8'h00;
  logic        lp_wr = 1'b0;
  logic        lp_wd = 1'b0;
  logic        rtc = 1'b0;
  logic        tick = 1'b0;
  logic [7:0]  exp_con;
  wire  [7:0]  trim, con;
  wire  [2:0]  src;
  wire         cen, pin, oe, lp, dbl;
  wire  [5:0]  rtrim;
  int          miscompares = 0, compares = 0, pulses = 0, edges, dp, de;
  logic [2:0]  codes [6] = '{`CCS_SRC_XHIGH, `CCS_SRC_XMED, `CCS_SRC_XLOW, `CCS_SRC_EXT, `CCS_SRC_RC, `CCS_SRC_WDOG};

  ccs_clock_ctrl #(.TRIM_FACTORY(TF)) i_dut (.i_mclk(mclk), .i_rst(rst), .i_sfr_wr(sfr_wr), .i_sfr_addr(sfr_addr),
    .i_xsfr_wr(xwr), .i_xsfr_addr(xaddr), .i_wdata(wdata), .o_trim_rdata(trim), .o_clock_switch_control_rdata(con),
    .i_user_config_byte_one(user_config_byte_one), .i_user_config_byte_two(user_config_byte_two), .i_low_power_clock_bit_wr(lp_wr),
    .i_low_power_clock_bit_wdata(lp_wd), .i_rtc_uses_crystal(rtc), .i_cpu_clock_divider(div),
    .i_osc_tick_xtal(tick), .i_osc_tick_rc(tick), .i_osc_tick_wdog(tick), .i_osc_tick_ext(tick),
    .o_active_source(src), .o_rc_doubled(dbl), .o_cpu_clock_en(cen), .o_periph_clock_en(), .o_crystal_for_watchdog(),
    .o_low_power_clock_bit(lp), .o_rc_trim(rtrim), .o_clock_output_pin(pin), .o_clock_output_pin_oe(oe));
  ccs_clock_output_pin_sink i_sink (.i_mclk(mclk), .i_pin(pin), .i_oe(oe), .o_edges(edges));

  always #50 mclk = ~mclk;
  always @(posedge mclk) begin
    tick <= #1 ~tick;
    if (cen) pulses++;
  end

  task automatic do_reset;
    rst = 1'b1;
    repeat (5) @(posedge mclk);
    #1 rst = 1'b0;
    @(posedge mclk);
    #1;
  endtask : do_reset

  // Extended space selects clock control, plain space the trim register
  task automatic wr(input logic x, input logic [15:0] a, input logic [7:0] d);
    @(posedge mclk);
    #1;
    if (x) begin
      xwr = 1'b1;
      xaddr = a;
    end else begin
      sfr_wr = 1'b1;
      sfr_addr = a[7:0];
    end
    wdata = d;
    @(posedge mclk);
    #1;
    xwr = 1'b0;
    sfr_wr = 1'b0;
  endtask : wr

  task automatic wait_done;
    int n;
    n = 0;
    while (con[7] !== 1'b1 && n < 4000) begin
      @(posedge mclk);
      #1 n++;
    end
    `CHK("switch done", 1'b1, con[7])
  endtask : wait_done

  task automatic finish_test;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : finish_test

  initial begin
    #(100 * 40000);
    miscompares++;
    finish_test;
  end

  initial begin
    do_reset;
    `CHK("trim reset", {2'b00, TF}, trim)
    `CHK("clock_switch_control reset", 8'h84, con)
    `CHK("low power reset", 1'b0, lp)
    `CHK("source reset", `CCS_SRC_WDOG, src)
    `CHK("doubler reset", 1'b0, dbl)
    $display("test reset done");
    wr(0, `CCS_TRIM_ADDR, trim | 8'h40);
    `CHK("trim enable", {2'b01, TF}, trim)
    `CHK("oe on", 1'b1, oe)
    dp = pulses;
    de = edges;
    repeat (200) @(posedge mclk);
    #1 dp = pulses - dp;
    de = edges - de;
    `CHK("cpu pulses", 1'b1, dp > 0)
    `CHK("clock_output_pin rate", 1'b1, (2 * de >= dp - 2) && (2 * de <= dp + 2))
    rtc = 1'b1;
    #1 `CHK("oe rtc", 1'b0, oe)
    rtc = 1'b0;
    wr(1, `CCS_CLOCK_SWITCH_CONTROL_ADDR, 8'h14);
    wait_done;
    `CHK("oe xwd", 1'b0, oe)
    wr(0, `CCS_TRIM_ADDR, (trim & 8'hC0) | 8'h15);
    `CHK("trim field", 8'h55, trim)
    `CHK("rc trim", 6'h15, rtrim)
    wr(0, 16'h0097, 8'h00);
    `CHK("trim unmapped", 8'h55, trim)
    wr(1, 16'hFFDF, 8'h00);
    `CHK("clock_switch_control unmapped", 8'h94, con)
    $display("test trim and clock out done");
    for (int i = 0; i < 6; i++) begin
      exp_con = {4'h0, codes[i] == `CCS_SRC_RC, codes[i]};
      wr(1, `CCS_CLOCK_SWITCH_CONTROL_ADDR, exp_con);
      `CHK("done low", 1'b0, con[7])
      wr(1, `CCS_CLOCK_SWITCH_CONTROL_ADDR, 8'h10);
      `CHK("busy write", exp_con, con)
      wait_done;
      `CHK("source", codes[i], src)
      `CHK("rc doubled", codes[i] == `CCS_SRC_RC, dbl)
      `CHK("clock_output_pin gate", codes[i] > 3'h2, oe)
    end
    $display("test switching done");
    wr(0, `CCS_TRIM_ADDR, trim | 8'h80);
    @(posedge mclk);
    #1 `CHK("rc override", `CCS_SRC_RC, src)
    wr(0, `CCS_TRIM_ADDR, trim & 8'h7F);
    @(posedge mclk);
    #1 `CHK("override off", `CCS_SRC_WDOG, src)
    @(posedge mclk);
    #1 lp_wr = 1'b1;
    lp_wd = 1'b1;
    @(posedge mclk);
    #1 lp_wr = 1'b0;
    `CHK("low power set", 1'b1, lp)
    div = 8'h02;
    dp = pulses;
    repeat (400) @(posedge mclk);
    #1 dp = pulses - dp;
    `CHK("divided pulses", 1'b1, (dp >= 49) && (dp <= 51))
    $display("test override and low power done");
    user_config_byte_one = 8'h2B;
    user_config_byte_two = 8'h80;
    do_reset;
    `CHK("trim rereset", {2'b00, TF}, trim)
    `CHK("low power rereset", 1'b0, lp)
    `CHK("clock_switch_control rereset", 8'h8B, con)
    `CHK("doubler rereset", 1'b1, dbl)
    `CHK("rc trim rereset", TF, rtrim)
    $display("test second reset done");
    finish_test;
  end
endmodule : ccs_clock_ctrl_tb

// *** test/ccs_clock_output_pin_sink.sv ***
// Far-side device that locks onto the clock output pin
`timescale 1ns/1ps
module ccs_clock_output_pin_sink (
  // Clock and pin
  input  wire logic i_mclk,
  input  wire logic i_pin,
  input  wire logic i_oe,
  // Rising edges seen while driven
  output int        o_edges
);
  logic last_q = 1'b0;
  logic lvl;
  int   edge_cnt = 0;
  assign o_edges = edge_cnt;
  // No pull on the pin: undriven it shows a changing level
  always_comb lvl = i_oe ? i_pin : ~last_q;
  always @(posedge i_mclk) begin
    if (i_oe && lvl && !last_q) edge_cnt <= edge_cnt + 1;
    last_q <= lvl;
  end
endmodule : ccs_clock_output_pin_sink

// *** verilog/ccs_cfg.svh ***
// Register offsets, field positions, reset values and timing counts of the clock source control
// How it works
// (R1) Clock output pin driven only while the crystal is unused by CPU, RTC and watchdog.
// (R2) Trim bit 6 enables the clock output; cleared disables it.
// (R3) Clock output toggles at half the CPU clock rate.
// (R4) Reset clears trim bits 7 and 6, loads trim field from factory value.
// (R5) Software preserves trim field when changing bits 6 or 7.
// (R6) Larger trim value lowers RC frequency; field writable any time.
// (R7) Doubler configuration bit doubles the RC oscillator output.
// (R8) Low-power clock bit clears on reset; software sets it only at 8 MHz or below.
// (R9) Trim bit 7 selects RC oscillator as CPU clock without reset.
// (R10) CPU clock switches among watchdog, RC, crystal and external clock while running.
// (R11) Switch-done flag is read-only, clears on switch start, sets on completion.
// (R12) Software does not write clock control while switch-done reads 0.
// (R13) Clock control resets from config bytes; bits 6..4 zero, bit 7 one.
// (R14) Source codes: 111 ext, 100 wdog, 011 RC, 010/001/000 crystals.
// (R15) Clock control bit 3 doubles the RC frequency for the switch.
// (R16) Clock control bit 4 selects crystal as watchdog clock.
// (R17) Brown-out hold bits must be enabled with doubler or fast external clock.
// (R18) Wake-up delay: crystal 1024 cycles plus 60..100 us, RC 200..300 us, others 32.
// (R19) CPU clock is oscillator clock divided by 2N; N of 0 passes undivided.
// (R20) Peripheral clock runs at half the CPU clock.
// (R21) Switch completes glitch-free after wake-up delay; done flag set same cycle.
`ifndef CCS_CFG_SVH
`define CCS_CFG_SVH
`define CCS_TRIM_ADDR      8'h96
`define CCS_CLOCK_SWITCH_CONTROL_ADDR    16'hFFDE
`define CCS_TRIM_RCSEL_BIT 7
`define CCS_TRIM_OUTEN_BIT 6
`define CCS_CON_DONE_BIT   7
`define CCS_CON_XWD_BIT    4
`define CCS_CON_DBL_BIT    3
`define CCS_CON_DONE_RST   1'b1
`define CCS_SRC_EXT        3'h7
`define CCS_SRC_WDOG       3'h4
`define CCS_SRC_RC         3'h3
`define CCS_SRC_XLOW       3'h2
`define CCS_SRC_XMED       3'h1
`define CCS_SRC_XHIGH      3'h0
`define CCS_CLK_HZ         10000000
`define CCS_XTAL_CYC       1024
`define CCS_XTAL_US        60
`define CCS_RC_US          200
`define CCS_FAST_CYC       32
`endif

// *** verilog/ccs_clock_ctrl.sv ***
// Clock source selection, switch sequencing, trim and clock output gating
`timescale 1ns/1ps
`include "ccs_cfg.svh"
module ccs_clock_ctrl #(
  parameter int  DIV_W     = 8,
  parameter logic [5:0] TRIM_FACTORY = 6'h20
) (
  // Clock and reset
  input  wire logic             i_mclk,
  input  wire logic             i_rst,
  // Special function register access
  input  wire logic             i_sfr_wr,
  input  wire logic [7:0]       i_sfr_addr,
  input  wire logic             i_xsfr_wr,
  input  wire logic [15:0]      i_xsfr_addr,
  input  wire logic [7:0]       i_wdata,
  output logic [7:0]            o_trim_rdata,
  output logic [7:0]            o_clock_switch_control_rdata,
  // Configuration bytes and other control bits
  input  wire logic [7:0]       i_user_config_byte_one,
  input  wire logic [7:0]       i_user_config_byte_two,
  input  wire logic             i_low_power_clock_bit_wr,
  input  wire logic             i_low_power_clock_bit_wdata,
  input  wire logic             i_rtc_uses_crystal,
  input  wire logic [DIV_W-1:0] i_cpu_clock_divider,
  // Oscillator edge strobes, one per source
  input  wire logic             i_osc_tick_xtal,
  input  wire logic             i_osc_tick_rc,
  input  wire logic             i_osc_tick_wdog,
  input  wire logic             i_osc_tick_ext,
  // Clock outputs and status
  output logic [2:0]            o_active_source,
  output logic                  o_rc_doubled,
  output logic                  o_cpu_clock_en,
  output logic                  o_periph_clock_en,
  output logic                  o_crystal_for_watchdog,
  output logic                  o_low_power_clock_bit,
  output logic [5:0]            o_rc_trim,
  output logic                  o_clock_output_pin,
  output logic                  o_clock_output_pin_oe
);
  // Registers
  logic [5:0]        trim_q, trim_d;
  logic              out_en_q, out_en_d;
  logic              rc_sel_q, rc_sel_d;
  ccs_pkg::ccs_src_t src_sel_q, src_sel_d;
  ccs_pkg::ccs_src_t act_src_q, act_src_d;
  logic              dbl_q, dbl_d;
  logic              act_dbl_q, act_dbl_d;
  logic              xwd_q, xwd_d;
  logic              lp_q, lp_d;
  logic              done_q, done_d;
  ccs_pkg::ccs_state_t st_q, st_d;
  logic [DIV_W-1:0]  div_cnt_q, div_cnt_d;
  logic              half_q, half_d;
  logic              cpu_en_q, cpu_en_d;
  logic              per_q, per_d;
  logic              pin_q, pin_d;
  logic              strap_q;

  logic              trim_wr, con_wr, start, expired, osc_tick, wake_tick, xtal_busy;
  ccs_pkg::ccs_src_t eff_src;
  ccs_pkg::ccs_src_t tgt_src;

  assign trim_wr = i_sfr_wr && (i_sfr_addr == `CCS_TRIM_ADDR);
  // Writes while switching are dropped; software should not issue them [R12]
  assign con_wr  = i_xsfr_wr && (i_xsfr_addr == `CCS_CLOCK_SWITCH_CONTROL_ADDR) && done_q;
  assign tgt_src = con_wr ? i_wdata[2:0] : src_sel_q;
  // A clock control write starts a switch [R10]
  assign start   = con_wr;

  ccs_wake_timer u_wake (
    .i_mclk     (i_mclk),
    .i_rst      (i_rst),
    .i_start    (start),
    .i_src      (tgt_src),
    .i_osc_tick (wake_tick),
    .o_expired  (expired)
  );

  // Trim bit 7 overrides the selected source [R9]
  assign eff_src = rc_sel_q ? `CCS_SRC_RC : act_src_q;

  // CPU divider keeps the running source while the wake timer counts the new one [R21]
  always_comb begin
    case (eff_src)
      `CCS_SRC_RC:   osc_tick = i_osc_tick_rc;
      `CCS_SRC_WDOG: osc_tick = i_osc_tick_wdog;
      `CCS_SRC_EXT:  osc_tick = i_osc_tick_ext;
      default:       osc_tick = i_osc_tick_xtal;
    endcase
    case (src_sel_q)
      `CCS_SRC_RC:   wake_tick = i_osc_tick_rc;
      `CCS_SRC_WDOG: wake_tick = i_osc_tick_wdog;
      `CCS_SRC_EXT:  wake_tick = i_osc_tick_ext;
      default:       wake_tick = i_osc_tick_xtal;
    endcase
  end

  // Register state and switch sequencing
  always_comb begin
    trim_d    = trim_q;
    out_en_d  = out_en_q;
    rc_sel_d  = rc_sel_q;
    src_sel_d = src_sel_q;
    act_src_d = act_src_q;
    dbl_d     = dbl_q;
    act_dbl_d = act_dbl_q;
    xwd_d     = xwd_q;
    lp_d      = lp_q;
    done_d    = done_q;
    st_d      = st_q;
    if (trim_wr) begin
      trim_d   = i_wdata[5:0];                       // [R6]
      out_en_d = i_wdata[`CCS_TRIM_OUTEN_BIT];       // [R2]
      rc_sel_d = i_wdata[`CCS_TRIM_RCSEL_BIT];       // [R9]
    end
    if (i_low_power_clock_bit_wr) begin
      lp_d = i_low_power_clock_bit_wdata;            // [R8]
    end
    case (st_q)
      ccs_pkg::CCS_IDLE, ccs_pkg::CCS_DONE: begin
        if (con_wr) begin
          src_sel_d = i_wdata[2:0];                  // [R14]
          dbl_d     = i_wdata[`CCS_CON_DBL_BIT];     // [R15]
          xwd_d     = i_wdata[`CCS_CON_XWD_BIT];     // [R16]
          done_d    = 1'b0;                          // [R11]
          st_d      = ccs_pkg::CCS_WAKE;
        end
      end
      ccs_pkg::CCS_WAKE: begin
        // Old source keeps running until the new one is stable [R21]
        if (expired) begin
          act_src_d = src_sel_q;                     // [R10]
          act_dbl_d = dbl_q;                         // [R7]
          done_d    = 1'b1;                          // [R21]
          st_d      = ccs_pkg::CCS_DONE;
        end
      end
      default: st_d = ccs_pkg::CCS_IDLE;
    endcase
  end

  // Divide by 2N, N of zero passes every oscillator edge [R19]
  always_comb begin
    div_cnt_d = div_cnt_q;
    half_d    = half_q;
    cpu_en_d  = 1'b0;
    if (osc_tick) begin
      if (i_cpu_clock_divider == '0) begin
        cpu_en_d = 1'b1;
      end else if (div_cnt_q >= i_cpu_clock_divider - DIV_W'(1)) begin
        div_cnt_d = '0;
        half_d    = ~half_q;
        cpu_en_d  = half_q;
      end else begin
        div_cnt_d = div_cnt_q + DIV_W'(1);
      end
    end
  end

  // Crystal busy as CPU, RTC or watchdog source [R1]
  assign xtal_busy = (eff_src == `CCS_SRC_XLOW) || (eff_src == `CCS_SRC_XMED) ||
                     (eff_src == `CCS_SRC_XHIGH) || i_rtc_uses_crystal || xwd_q ||
                     // A crystal being woken already owns the pin
                     ((st_q == ccs_pkg::CCS_WAKE) && (src_sel_q < `CCS_SRC_RC));

  always_comb begin
    per_d = per_q;
    pin_d = pin_q;
    if (cpu_en_q) begin
      per_d = ~per_q;                                // [R20]
      pin_d = ~pin_q;                                // [R3]
    end
    if (!(out_en_q && !xtal_busy)) begin
      pin_d = 1'b0;                                  // [R1] [R2]
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      trim_q    <= TRIM_FACTORY;                     // [R4]
      out_en_q  <= 1'b0;                             // [R4]
      rc_sel_q  <= 1'b0;                             // [R4]
      lp_q      <= 1'b0;                             // [R8]
      xwd_q     <= 1'b0;                             // [R13]
      done_q    <= `CCS_CON_DONE_RST;                // [R13]
      st_q      <= ccs_pkg::CCS_IDLE;
      strap_q   <= 1'b1;
      src_sel_q <= `CCS_SRC_XHIGH;
      act_src_q <= `CCS_SRC_XHIGH;
      dbl_q     <= 1'b0;
      act_dbl_q <= 1'b0;
      div_cnt_q <= '0;
      half_q    <= 1'b0;
      cpu_en_q  <= 1'b0;
      per_q     <= 1'b0;
      pin_q     <= 1'b0;
    end else begin
      trim_q    <= trim_d;
      out_en_q  <= out_en_d;
      rc_sel_q  <= rc_sel_d;
      lp_q      <= lp_d;
      xwd_q     <= xwd_d;
      done_q    <= done_d;
      st_q      <= st_d;
      strap_q   <= 1'b0;
      // Configuration bytes caught at the first edge after release [R13]
      if (strap_q) begin
        src_sel_q <= i_user_config_byte_one[2:0];
        act_src_q <= i_user_config_byte_one[2:0];
        dbl_q     <= i_user_config_byte_two[7];
        act_dbl_q <= i_user_config_byte_two[7];
      end else begin
        src_sel_q <= src_sel_d;
        act_src_q <= act_src_d;
        dbl_q     <= dbl_d;
        act_dbl_q <= act_dbl_d;
      end
      div_cnt_q <= div_cnt_d;
      half_q    <= half_d;
      cpu_en_q  <= cpu_en_d;
      per_q     <= per_d;
      pin_q     <= pin_d;
    end
  end

  // Read data; bits 6 and 5 of clock control read zero
  assign o_trim_rdata   = {rc_sel_q, out_en_q, trim_q};
  assign o_clock_switch_control_rdata = {done_q, 2'b00, xwd_q, dbl_q, src_sel_q};
  assign o_active_source        = eff_src;
  assign o_rc_doubled           = act_dbl_q;
  assign o_cpu_clock_en         = cpu_en_q;
  assign o_periph_clock_en      = cpu_en_q && per_q;
  assign o_crystal_for_watchdog = xwd_q;
  assign o_low_power_clock_bit  = lp_q;
  assign o_rc_trim              = trim_q;
  assign o_clock_output_pin     = pin_q;
  assign o_clock_output_pin_oe  = out_en_q && !xtal_busy;
endmodule : ccs_clock_ctrl

// *** verilog/ccs_pkg.sv ***
// Types shared by the clock source control files
package ccs_pkg;
  typedef enum logic [1:0] {
    CCS_IDLE,
    CCS_WAKE,
    CCS_DONE
  } ccs_state_t;
  typedef logic [2:0] ccs_src_t;
endpackage : ccs_pkg

// *** verilog/ccs_wake_timer.sv ***
// Wake-up delay counter for a newly selected oscillator source
`timescale 1ns/1ps
`include "ccs_cfg.svh"
module ccs_wake_timer #(
  parameter int CNT_W = 16
) (
  // Clock and reset
  input  wire logic             i_mclk,
  input  wire logic             i_rst,
  // Control
  input  wire logic             i_start,
  input  wire ccs_pkg::ccs_src_t i_src,
  input  wire logic             i_osc_tick,
  // Status
  output logic                  o_expired
);
  // Microsecond parts scaled to system clock cycles by the clock rate in whole MHz, rounded down
  localparam int XTAL_US_CYC = (`CCS_XTAL_US * (`CCS_CLK_HZ / 1000000));
  localparam int RC_US_CYC   = (`CCS_RC_US * (`CCS_CLK_HZ / 1000000));

  logic [CNT_W-1:0] osc_cnt_q, osc_cnt_d;
  logic [CNT_W-1:0] us_cnt_q, us_cnt_d;
  logic [CNT_W-1:0] osc_goal;
  logic [CNT_W-1:0] us_goal;
  logic             run_q, run_d;

  always_comb begin
    // Crystal counts oscillator edges then settles; RC waits time only [R18]
    case (i_src)
      `CCS_SRC_XLOW, `CCS_SRC_XMED, `CCS_SRC_XHIGH: begin
        osc_goal = CNT_W'(`CCS_XTAL_CYC);
        us_goal  = CNT_W'(XTAL_US_CYC);
      end
      `CCS_SRC_RC: begin
        osc_goal = '0;
        us_goal  = CNT_W'(RC_US_CYC);
      end
      default: begin
        osc_goal = CNT_W'(`CCS_FAST_CYC);
        us_goal  = '0;
      end
    endcase
  end

  always_comb begin
    osc_cnt_d = osc_cnt_q;
    us_cnt_d  = us_cnt_q;
    run_d     = run_q;
    if (i_start) begin
      osc_cnt_d = '0;
      us_cnt_d  = '0;
      run_d     = 1'b1;
    end else if (run_q) begin
      if (osc_cnt_q < osc_goal) begin
        if (i_osc_tick) begin
          osc_cnt_d = osc_cnt_q + CNT_W'(1);
        end
      end else if (us_cnt_q < us_goal) begin
        us_cnt_d = us_cnt_q + CNT_W'(1);
      end else begin
        run_d = 1'b0;
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      osc_cnt_q <= '0;
      us_cnt_q  <= '0;
      run_q     <= 1'b0;
    end else begin
      osc_cnt_q <= osc_cnt_d;
      us_cnt_q  <= us_cnt_d;
      run_q     <= run_d;
    end
  end

  assign o_expired = run_q && (osc_cnt_q >= osc_goal) && (us_cnt_q >= us_goal);
endmodule : ccs_wake_timer
